/* hdl/vsp_top.sv */
// Four-channel variable-speed pulse train with direction outputs
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module vsp_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Motor drive pins
  output logic [vsp_pkg::NUM_CH-1:0] pulse_out_o,
  output logic [vsp_pkg::NUM_CH-1:0] dir_out_o,
  // Interrupt
  output logic irq_o
);
  import vsp_pkg::*;

  // Per-channel engine state
  typedef struct packed {
    vsp_state_e_t st;
    logic stopping;
    logic no_done;
    logic abn;
    logic dir;
    logic pulse;
    logic act_q;
    logic [FREQ_W-1:0] cur;
    logic [25:0] phase;
    logic [31:0] racc;
    logic [31:0] pos;
    logic done;
    logic abort;
    logic refused;
  } vsp_chan_t;

  typedef struct packed {
    vsp_chan_t [NUM_CH-1:0] ch;
  } vsp_top_t;

  vsp_top_t s, next_s;

  logic ramp_en;
  logic [3:0][31:0] target;
  logic [3:0][3:0] ctrl;
  logic [3:0][31:0] ramp;
  logic [3:0] busy;
  logic [3:0] dir;
  logic [3:0][31:0] pos;
  logic [11:0] events;

  // Clamped magnitude of a signed target frequency
  function automatic logic [FREQ_W-1:0] vsp_mag(input logic [31:0] t,
                                               input logic adapter);
    logic [31:0] m;
    logic [31:0] lim;
    m = t[31] ? 32'(-t) : t;
    lim = adapter ? LIMIT_ADAPTER_HZ : LIMIT_MAIN_HZ;
    if (m > lim) begin
      m = lim;
    end
    return m[FREQ_W-1:0];
  endfunction

  // Register bank and interrupt logic
  vsp_regs u_regs (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .busy_i(busy),
    .dir_i(dir),
    .pos_i(pos),
    .event_i(events),
    .ramp_en_o(ramp_en),
    .target_o(target),
    .ctrl_o(ctrl),
    .ramp_o(ramp),
    .irq_o(irq_o)
  );

  // Status and event taps from the engine flops
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_tap
      assign busy[g] = (s.ch[g].st != VSP_IDLE);
      assign dir[g] = s.ch[g].dir;
      assign pos[g] = s.ch[g].pos;
      assign events[STAT_DONE_LSB + g] = s.ch[g].done;
      assign events[STAT_ABN_LSB + g] = s.ch[g].abort;
      assign events[STAT_REF_LSB + g] = s.ch[g].refused;
      // Fixed pairing: pulse n always travels with direction n
      assign pulse_out_o[g] = s.ch[g].pulse;
      assign dir_out_o[g] = s.ch[g].dir;
    end
  endgenerate

  // Channel engines: start, ramp, oscillator, position and stop causes
  always_comb begin
    vsp_chan_t c;
    logic act;
    logic tzero;
    logic sign_bad;
    logic lim_hit;
    logic [FREQ_W-1:0] mag;
    logic [FREQ_W-1:0] goal;
    logic [15:0] rate_ms;
    logic [31:0] thr;
    logic [31:0] racc_sum;
    logic [26:0] ph_sum;
    logic next_pulse;
    c = '0;
    act = 1'b0;
    tzero = 1'b0;
    sign_bad = 1'b0;
    lim_hit = 1'b0;
    mag = '0;
    goal = '0;
    rate_ms = 16'h0;
    thr = 32'h0;
    racc_sum = 32'h0;
    ph_sum = 27'h0;
    next_pulse = 1'b0;
    next_s = s;
    for (int i = 0; i < NUM_CH; i++) begin
      c = s.ch[i];
      c.done = 1'b0;
      c.abort = 1'b0;
      c.refused = 1'b0;
      act = ctrl[i][ACT_BIT];
      c.act_q = act;
      tzero = (target[i] == 32'h0);
      mag = vsp_mag(target[i], ctrl[i][ADAPTER_BIT]);
      // A start edge while the channel is still busy is rejected
      if (act && !s.ch[i].act_q && s.ch[i].st != VSP_IDLE) begin
        c.refused = 1'b1;
      end
      unique case (s.ch[i].st)
        VSP_IDLE: begin
          c.dir = 1'b0;
          c.pulse = 1'b0;
          c.cur = '0;
          c.phase = '0;
          c.racc = '0;
          c.stopping = 1'b0;
          c.no_done = 1'b0;
          c.abn = 1'b0;
          // Restart needs only activation and a nonzero target
          if (act && !tzero) begin
            c.dir = !target[i][31];
            c.st = VSP_PREP;
          end
        end
        VSP_PREP: begin
          // One cycle of settled direction before any pulse edge
          c.st = VSP_RUN;
        end
        VSP_RUN: begin
          lim_hit = s.ch[i].dir ? ctrl[i][FWD_LIM_BIT]
                                : ctrl[i][REV_LIM_BIT];
          // Sign flip is treated as a stop request rather than a reversal
          sign_bad = (target[i][31] == s.ch[i].dir) && !tzero;
          if (!act) begin
            c.stopping = 1'b1;
            c.no_done = 1'b1;
          end
          if (lim_hit) begin
            c.stopping = 1'b1;
            c.abn = 1'b1;
          end
          if (tzero || sign_bad) begin
            c.stopping = 1'b1;
          end
          goal = c.stopping ? '0 : mag;
          // Ramp: one 1 Hz step whenever the rate accumulator wraps
          if (!ramp_en) begin
            c.cur = goal;
            c.racc = '0;
          end else if (s.ch[i].cur != goal) begin
            rate_ms = (s.ch[i].cur < goal) ? ramp[i][ACCEL_LSB +: 16]
                                           : ramp[i][DECEL_LSB +: 16];
            thr = 32'(rate_ms * CYC_PER_MS);
            racc_sum = s.ch[i].racc + MAX_SPEED_HZ;
            if (rate_ms == 16'h0) begin
              c.cur = goal;
              c.racc = '0;
            end else if (racc_sum >= thr) begin
              // Slope is max speed over the set time, linear, for set times of 2 ms or more
              c.racc = racc_sum - thr;
              c.cur = (s.ch[i].cur < goal) ? s.ch[i].cur + 1'b1
                                           : s.ch[i].cur - 1'b1;
            end else begin
              c.racc = racc_sum;
            end
          end else begin
            c.racc = '0;
          end
          // Phase oscillator; pulse high for the upper half of a period
          ph_sum = {1'b0, s.ch[i].phase} + 27'(c.cur);
          if (ph_sum >= {1'b0, PHASE_WRAP}) begin
            ph_sum = ph_sum - {1'b0, PHASE_WRAP};
          end
          c.phase = ph_sum[25:0];
          next_pulse = (c.phase >= PHASE_HALF);
          if (c.cur == '0) begin
            next_pulse = 1'b0;
          end
          c.pulse = next_pulse;
          // Count on each rising pulse edge in the latched direction
          if (next_pulse && !s.ch[i].pulse) begin
            c.pos = s.ch[i].dir ? s.ch[i].pos + 32'h1
                                : s.ch[i].pos - 32'h1;
          end
          // Busy stays up until the frequency has reached zero
          if (c.stopping && c.cur == '0) begin
            c.st = VSP_IDLE;
            c.pulse = 1'b0;
            c.dir = 1'b0;
            c.phase = '0;
            c.abort = c.abn;
            c.done = !c.abn && !c.no_done;
          end
        end
        default: begin
          c.st = VSP_IDLE;
          c.pulse = 1'b0;
          c.dir = 1'b0;
        end
      endcase
      next_s.ch[i] = c;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* inc/vsp_pkg.sv */
// Constants and types for the variable-speed pulse/direction output block
package vsp_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RAMP_UNIT_MS = 1;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * RAMP_UNIT_MS;
  localparam logic [25:0] PHASE_WRAP = 26'(CLK_HZ);
  localparam logic [25:0] PHASE_HALF = 26'(CLK_HZ / 2);

  // Channel count, frequency width, limits in Hz and default ramp time
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned FREQ_W = 18;
  localparam logic [31:0] LIMIT_ADAPTER_HZ = 32'd200_000;
  localparam logic [31:0] LIMIT_MAIN_HZ = 32'd100_000;
  localparam logic [31:0] MAX_SPEED_HZ = 32'd100_000;
  localparam logic [15:0] RAMP_DEFAULT_MS = 16'd100;

  // Global register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_RUN = 8'h0c;

  // Per-channel block: base 0x10, stride 0x10, offsets inside
  localparam logic [3:0] CH_FIRST_PAGE = 4'h1;
  localparam logic [3:0] CH_TARGET = 4'h0;
  localparam logic [3:0] CH_CTRL = 4'h4;
  localparam logic [3:0] CH_RAMP = 4'h8;
  localparam logic [3:0] CH_POS = 4'hc;

  // Field positions
  localparam int unsigned CTRL_RAMP_EN_BIT = 0;
  localparam int unsigned ACT_BIT = 0;
  localparam int unsigned FWD_LIM_BIT = 1;
  localparam int unsigned REV_LIM_BIT = 2;
  localparam int unsigned ADAPTER_BIT = 3;
  localparam int unsigned ACCEL_LSB = 0;
  localparam int unsigned DECEL_LSB = 16;
  localparam int unsigned STAT_DONE_LSB = 0;
  localparam int unsigned STAT_ABN_LSB = 4;
  localparam int unsigned STAT_REF_LSB = 8;
  localparam int unsigned RUN_BUSY_LSB = 0;
  localparam int unsigned RUN_DIR_LSB = 4;

  // Reset values
  localparam logic [31:0] RAMP_RESET = {RAMP_DEFAULT_MS, RAMP_DEFAULT_MS};
  localparam logic [11:0] STAT_RESET = 12'h000;
  localparam logic [11:0] MASK_RESET = 12'h000;

  // Channel sequencer states
  typedef enum logic [1:0] {
    VSP_IDLE = 2'b00,
    VSP_PREP = 2'b01,
    VSP_RUN = 2'b10
  } vsp_state_e_t;

endpackage

/* hdl/vsp_regs.sv */
// Wishbone register bank with sticky interrupt status for the pulse block
`timescale 1ns/1ps
module vsp_regs (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Channel status and events
  input wire logic [3:0] busy_i,
  input wire logic [3:0] dir_i,
  input wire logic [3:0][31:0] pos_i,
  input wire logic [11:0] event_i,
  // Configuration to the engines
  output logic ramp_en_o,
  output logic [3:0][31:0] target_o,
  output logic [3:0][3:0] ctrl_o,
  output logic [3:0][31:0] ramp_o,
  // Interrupt
  output logic irq_o
);
  import vsp_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic ramp_en;
    logic [11:0] stat;
    logic [11:0] mask;
    logic [3:0][31:0] target;
    logic [3:0][3:0] ctrl;
    logic [3:0][31:0] ramp;
    logic irq;
  } vsp_regs_t;

  vsp_regs_t s, next_s;

  // Byte-lane merge, used for the target, ramp and mask registers and the status clear mask
  function automatic logic [31:0] vsp_merge(input logic [31:0] old,
                                            input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bus decode, register update and interrupt combine
  always_comb begin
    logic take;
    logic [31:0] wmask;
    logic [3:0] page;
    logic [3:0] off;
    logic [31:0] rd;
    int ch;
    logic [31:0] mrg;
    take = 1'b0;
    wmask = 32'h0;
    page = 4'h0;
    off = 4'h0;
    rd = 32'h0;
    ch = 0;
    mrg = 32'h0;
    next_s = s;
    take = wb_cyc_i && wb_stb_i && !s.ack;
    page = wb_adr_i[7:4];
    off = wb_adr_i[3:0];
    wmask = vsp_merge(32'h0, 32'hffff_ffff, wb_sel_i);
    next_s.ack = take;
    if (page == 4'h0) begin
      unique case (off)
        REG_CTRL[3:0]: rd = {31'h0, s.ramp_en};
        REG_IRQ_STAT[3:0]: rd = {20'h0, s.stat};
        REG_IRQ_MASK[3:0]: rd = {20'h0, s.mask};
        REG_RUN[3:0]: rd = {24'h0, dir_i, busy_i};
        default: rd = 32'h0;
      endcase
    end else if (page >= CH_FIRST_PAGE && page < 4'(CH_FIRST_PAGE + 4)) begin
      ch = int'(page - CH_FIRST_PAGE);
      unique case (off)
        CH_TARGET: rd = s.target[ch];
        CH_CTRL: rd = {28'h0, s.ctrl[ch]};
        CH_RAMP: rd = s.ramp[ch];
        CH_POS: rd = pos_i[ch];
        default: rd = 32'h0;
      endcase
    end
    if (take && !wb_we_i) begin
      next_s.dat = rd;
    end
    // Writes land on the edge that raises ack; unmapped ones are dropped
    if (take && wb_we_i) begin
      if (page == 4'h0) begin
        if (off == REG_CTRL[3:0] && wb_sel_i[0]) begin
          next_s.ramp_en = wb_dat_i[CTRL_RAMP_EN_BIT];
        end
        if (off == REG_IRQ_STAT[3:0]) begin
          next_s.stat = s.stat & ~(wb_dat_i[11:0] & wmask[11:0]);
        end
        if (off == REG_IRQ_MASK[3:0]) begin
          // Merge into a full word first; a call result cannot be sliced
          mrg = vsp_merge({20'h0, s.mask}, wb_dat_i, wb_sel_i);
          next_s.mask = mrg[11:0];
        end
      end else if (page >= CH_FIRST_PAGE &&
                   page < 4'(CH_FIRST_PAGE + 4)) begin
        if (off == CH_TARGET) begin
          next_s.target[ch] = vsp_merge(s.target[ch], wb_dat_i, wb_sel_i);
        end
        if (off == CH_CTRL && wb_sel_i[0]) begin
          next_s.ctrl[ch] = wb_dat_i[3:0];
        end
        if (off == CH_RAMP) begin
          next_s.ramp[ch] = vsp_merge(s.ramp[ch], wb_dat_i, wb_sel_i);
        end
      end
    end
    // Set wins over a same-cycle write-one clear, so no event is lost
    next_s.stat = next_s.stat | event_i;
    next_s.irq = |(next_s.stat & next_s.mask);
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '{ack: 1'b0, dat: 32'h0, ramp_en: 1'b0, stat: STAT_RESET,
             mask: MASK_RESET, target: '0, ctrl: '0,
             ramp: {NUM_CH{RAMP_RESET}}, irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign ramp_en_o = s.ramp_en;
  assign target_o = s.target;
  assign ctrl_o = s.ctrl;
  assign ramp_o = s.ramp;
  assign irq_o = s.irq;

endmodule

/* dv/vsp_assertions.sv */
// Port-level checker for the pulse/direction block
`timescale 1ns/1ps
module vsp_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Drive pins and interrupt
  input wire logic [3:0] pulse_out_o,
  input wire logic [3:0] dir_out_o,
  input wire logic irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [3:0] prev;
  logic [3:0] rise;
  logic [3:0][8:0] gap;
  assign rise = pulse_out_o & ~prev;
  // Cycles since last rising pulse, saturating so idle never wraps
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev <= 4'h0;
      gap <= {4{9'h1ff}};
    end else begin
      prev <= pulse_out_o;
      for (int i = 0; i < 4; i++) begin
        if (rise[i]) gap[i] <= 9'h000;
        else if (gap[i] != 9'h1ff) gap[i] <= gap[i] + 9'h001;
      end
    end
  end
  // Bus handshake
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack_once; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_take |=> s_ack_once; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_dat_hold; $changed(wb_dat_o) |-> wb_ack_o; endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  // Direction must be settled at every step edge and at run end; the lead after a direction rise is checked on channel 0 only
  property p_dir_steady;
    |rise |-> ((dir_out_o ^ $past(dir_out_o)) & rise) == 4'h0;
  endproperty
  a_dir_steady: assert property (p_dir_steady)
    else $error("direction moved at pulse");
  property p_dir_lead;
    $rose(dir_out_o[0]) |-> !pulse_out_o[0] ##1 !pulse_out_o[0];
  endproperty
  a_dir_lead: assert property (p_dir_lead)
    else $error("pulse too soon after direction");
  property p_dir_end;
    ((~dir_out_o & $past(dir_out_o)) & pulse_out_o) == 4'h0;
  endproperty
  a_dir_end: assert property (p_dir_end)
    else $error("pulse high as run ended");
  // No channel steps faster than the highest cap
  property p_gap(int i); rise[i] |-> gap[i] >= 9'h0f9; endproperty
  for (genvar i = 0; i < 4; i++) begin : g_gap
    a_gap: assert property (p_gap(i))
      else $error("pulse rate over cap");
  end
  // Clear and ack leave the same edge, so both are seen together
  property p_irq_fall;
    $fell(irq_o) |-> wb_ack_o;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule
bind vsp_top vsp_chk u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pulse_out_o(pulse_out_o), .dir_out_o(dir_out_o),
  .irq_o(irq_o));

/* dv/vsp_drive_model.sv */
// Motor drive stand-in counting steps and pulse spacing
`timescale 1ns/1ps
module vsp_drive_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Pulse and direction pins, only observed, never reused
  input wire logic [3:0] pulse_i,
  input wire logic [3:0] dir_i,
  // Observed motion
  output logic [3:0][31:0] steps_o,
  output logic [3:0][15:0] period_o
);
  logic [3:0] prev;
  logic [3:0][15:0] since;
  // Step on rising pulse, sense from the paired pin
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev <= 4'h0;
      steps_o <= '0;
      period_o <= '0;
      since <= '0;
    end else begin
      prev <= pulse_i;
      for (int i = 0; i < 4; i++) begin
        since[i] <= since[i] + 16'h0001;
        if (pulse_i[i] && !prev[i]) begin
          steps_o[i] <= dir_i[i] ? steps_o[i] + 32'h1 : steps_o[i] - 32'h1;
          period_o[i] <= since[i] + 16'h0001;
          since[i] <= 16'h0000;
        end
      end
    end
  end
endmodule

/* dv/vsp_top_tb.sv */
// Self-checking bench for the pulse/direction block
`timescale 1ns/1ps
module vsp_top_tb;
  import vsp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic irq;
  logic [3:0] pulse;
  logic [3:0] dir;
  logic [3:0][31:0] steps;
  logic [3:0][15:0] period;
  int bad_count = 0;
  int compares = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  vsp_top dut (.core_clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pulse_out_o(pulse), .dir_out_o(dir), .irq_o(irq));
  vsp_drive_model u_drive (.core_clk_i(clk), .rstn_i(rstn),
    .pulse_i(pulse), .dir_i(dir), .steps_o(steps), .period_o(period));
  task report_and_stop;
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle; waits for ack, bounded
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
    if (ack !== 1'b1) begin
      bad_count++;
      report_and_stop;
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Poll busy bits until all clear; software may restart only then
  task wait_idle;
    int n;
    for (n = 0; n < 4000; n++) begin
      wb(1'b0, REG_RUN, 32'h0);
      if (rd[3:0] === 4'h0) break;
    end
    if (n == 4000) begin
      bad_count++;
      report_and_stop;
    end
  endtask
  initial begin
    idle(10);
    rstn <= 1'b1;
    // Reset values and an unmapped hole
    rdchk(8'h18, RAMP_RESET);
    rdchk(REG_RUN, 32'h0);
    wr(8'h50, 32'hffffffff);
    rdchk(8'h50, 32'h0);
    rdchk(REG_CTRL, 32'h0);
    wr(REG_IRQ_MASK, 32'hfff);
    // Forward, ramp off: main cap, then adapter cap mid-run
    wr(8'h10, 32'h30d40);
    wr(8'h14, 32'h1);
    idle(1200);
    chk(period[0], 32'h1f4);
    chk(dir[0], 32'h1);
    wr(8'h14, 32'h9);
    idle(600);
    chk(period[0], 32'hfa);
    wr(8'h10, 32'h0);
    idle(3);
    chk(dir[0], 32'h0);
    rdchk(8'h1c, steps[0]);
    rdchk(REG_IRQ_STAT, 32'h1);
    chk(irq, 32'h1);
    wr(REG_IRQ_STAT, 32'h1);
    idle(3);
    chk(irq, 32'h0);
    // Reverse run ended by dropping activation
    wr(8'h20, 32'hfffcf2c0);
    wr(8'h24, 32'h9);
    idle(600);
    rdchk(REG_RUN, 32'h2);
    wr(8'h24, 32'h0);
    idle(3);
    rdchk(8'h2c, steps[1]);
    chk(steps[1][31], 32'h1);
    rdchk(REG_IRQ_STAT, 32'h0);
    // Only the limit of the travel direction ends the run
    wr(8'h30, 32'h30d40);
    wr(8'h34, 32'hd);
    idle(300);
    rdchk(REG_RUN, 32'h44);
    wr(8'h34, 32'hb);
    idle(3);
    rdchk(REG_IRQ_STAT, 32'h40);
    wr(8'h34, 32'h0);
    wr(8'h30, 32'h0);
    wr(REG_IRQ_STAT, 32'h40);
    // Global ramp; activation dropped and retried while busy
    wr(REG_CTRL, 32'h1);
    wr(8'h48, 32'h10000);
    wr(8'h40, 32'h1f4);
    wr(8'h44, 32'h1);
    idle(20);
    rdchk(REG_RUN, 32'h88);
    wr(8'h44, 32'h0);
    wr(8'h44, 32'h1);
    rdchk(REG_RUN, 32'h88);
    rdchk(REG_IRQ_STAT, 32'h800);
    wr(8'h44, 32'h0);
    wait_idle;
    rdchk(REG_IRQ_STAT, 32'h800);
    wr(REG_IRQ_STAT, 32'h800);
    // Ramped stop on a zero target keeps busy, then flags completion
    idle(1);
    wr(8'h44, 32'h1);
    idle(20);
    wr(8'h40, 32'h0);
    rdchk(REG_RUN, 32'h88);
    wait_idle;
    rdchk(REG_IRQ_STAT, 32'h8);
    wr(8'h44, 32'h0);
    wr(REG_IRQ_STAT, 32'h8);
    report_and_stop;
  end
endmodule
